// ==== tcm_freq_monitor.sv ====
// TMDS clock frequency monitor with its serial control bus register slice.
// Assumes reg_* come from the serial control bus decoder on clk; pins are async.
`timescale 1ns/1ps
`include "tcm_params.svh"
module tcm_freq_monitor
    import tcm_pkg::*;
#(
    parameter int STAB3_CYC = `TCM_NS2CYC(`TCM_STAB3_NS)
)
(
    input  wire logic      clk,
    input  wire logic      resetn,
    input  wire logic      tmds_clk,
    input  wire logic      pll_clk,
    input  wire logic      plus_5v_detect,
    input  wire logic      back_channel_link_detect,
    input  wire logic      swap_detect,
    input  wire logic      mode_change,
    input  wire tcm_byte_t reg_addr,
    input  wire tcm_byte_t reg_wdata,
    input  wire logic      reg_wr,
    input  wire logic      reg_rd,
    output tcm_byte_t      reg_rdata,
    output logic           clock_present,
    output logic           link_ready,
    output logic           lane_swap,
    output logic           pll_reset,
    output logic           phy_reset
);
    // Control fields
    logic       swap_inhibit_r, link_ovr_r, clk_ovr_r, pll_roc_r, phy_policy_r;
    tcm_src_t   meter_src_r;
    logic [1:0] stability_time_select_r;
    logic [2:0] measure_deadband_r;
    logic [5:0] tmds_min_mhz_r;
    logic [6:0] tmds_max_mhz_r;
    // Monitor state
    tcm_byte_t  cur_mhz_r, meas_mhz;
    tcm_cnt_t   stab_cnt_r, stab_lim;
    logic       stable_r, clk_valid_r, meas_done, chg;
    // Pin synchronisers
    logic       p5_q1_r, p5_q2_r, bcl_q1_r, bcl_q2_r, swp_q1_r, swp_q2_r;

    // Absolute difference of two MHz values
    function automatic tcm_byte_t abs_diff(input tcm_byte_t a, input tcm_byte_t b);
        abs_diff = (a > b) ? (a - b) : (b - a);
    endfunction

    // Stability time in block clock cycles for each select code
    function automatic tcm_cnt_t stab_cycles(input logic [1:0] sel);
        case (sel)
            2'h0:    stab_cycles = 16'(`TCM_NS2CYC(`TCM_STAB0_NS));
            2'h1:    stab_cycles = 16'(`TCM_NS2CYC(`TCM_STAB1_NS));
            2'h2:    stab_cycles = 16'(`TCM_NS2CYC(`TCM_STAB2_NS));
            default: stab_cycles = 16'(STAB3_CYC);
        endcase
    endfunction

    tcm_edge_meter u_meter (
        .clk       (clk),
        .resetn    (resetn),
        .tmds_clk  (tmds_clk),
        .pll_clk   (pll_clk),
        .src_sel   (meter_src_r),
        .meas_done (meas_done),
        .meas_mhz  (meas_mhz)
    );

    // Level pins from outside the clock domain
    always_ff @(posedge clk) begin
        if (!resetn) begin
            p5_q1_r  <= 1'b0;
            p5_q2_r  <= 1'b0;
            bcl_q1_r <= 1'b0;
            bcl_q2_r <= 1'b0;
            swp_q1_r <= 1'b0;
            swp_q2_r <= 1'b0;
        end else begin
            p5_q1_r  <= plus_5v_detect;
            p5_q2_r  <= p5_q1_r;
            bcl_q1_r <= back_channel_link_detect;
            bcl_q2_r <= bcl_q1_r;
            swp_q1_r <= swap_detect;
            swp_q2_r <= swp_q1_r;
        end
    end

    // Register writes; reserved bits are simply not stored
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pll_roc_r               <= `TCM_RST_PLL_ROC;
            meter_src_r             <= TCM_SRC_TMDS;
            swap_inhibit_r          <= 1'b0;
            link_ovr_r              <= 1'b0;
            clk_ovr_r               <= 1'b0;
            stability_time_select_r <= 2'h0;
            measure_deadband_r      <= `TCM_RST_DEADBAND;
            phy_policy_r            <= 1'b0;
            tmds_min_mhz_r          <= `TCM_RST_MIN_MHZ;
            tmds_max_mhz_r          <= `TCM_RST_MAX_MHZ;
        end else if (reg_wr) begin
            if (reg_addr == `TCM_ADDR_LINK_CTL) begin
                pll_roc_r   <= reg_wdata[`TCM_BIT_PLL_ROC];
                meter_src_r <= tcm_src_t'(reg_wdata[`TCM_BIT_METER_SRC]);
            end else if (reg_addr == `TCM_ADDR_DUAL_LINK_CONTROL_TWO) begin
                swap_inhibit_r          <= reg_wdata[`TCM_BIT_SWAP_INHIBIT];
                link_ovr_r              <= reg_wdata[`TCM_BIT_LINK_OVR];
                clk_ovr_r               <= reg_wdata[`TCM_BIT_CLK_OVR];
                stability_time_select_r <= reg_wdata[`TCM_STAB_MSB:`TCM_STAB_LSB];
                measure_deadband_r      <= reg_wdata[`TCM_DB_MSB:0];
            end else if (reg_addr == `TCM_ADDR_LOW_LIMIT) begin
                phy_policy_r   <= reg_wdata[`TCM_BIT_PHY_POLICY];
                tmds_min_mhz_r <= reg_wdata[`TCM_MIN_MSB:0];
            end else if (reg_addr == `TCM_ADDR_HIGH_LIMIT) begin
                tmds_max_mhz_r <= reg_wdata[`TCM_MAX_MSB:0];
            end
        end
    end

    // Swap state follows detection unless software has taken it over
    always_ff @(posedge clk) begin
        if (!resetn) begin
            lane_swap <= 1'b0;
        end else if (!swap_inhibit_r) begin
            lane_swap <= swp_q2_r;
        end else if (reg_wr && reg_addr == `TCM_ADDR_LINK_CTL) begin
            lane_swap <= reg_wdata[`TCM_BIT_SWAP_STATE];
        end
    end

    // A measurement outside the deadband replaces the held value
    assign chg      = meas_done && (abs_diff(meas_mhz, cur_mhz_r) > {5'h00, measure_deadband_r});
    assign stab_lim = stab_cycles(stability_time_select_r);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cur_mhz_r  <= 8'h00;
            stab_cnt_r <= 16'h0000;
            stable_r   <= 1'b0;
        end else if (chg) begin
            cur_mhz_r  <= meas_mhz;
            stab_cnt_r <= 16'h0000;
            stable_r   <= 1'b0;
        end else begin
            // Saturate so a long-stable clock never wraps back to unstable
            if (stab_cnt_r != 16'hFFFF) begin
                stab_cnt_r <= stab_cnt_r + 16'h0001;
            end
            stable_r <= (stab_cnt_r >= stab_lim);
        end
    end

    // Valid needs stability and both limits; override bypasses all checks
    always_ff @(posedge clk) begin
        if (!resetn) begin
            clk_valid_r   <= 1'b0;
            clock_present <= 1'b0;
            link_ready    <= 1'b0;
        end else begin
            clk_valid_r   <= stable_r && !chg && (cur_mhz_r >= {2'h0, tmds_min_mhz_r})
                             && (cur_mhz_r <= {1'b0, tmds_max_mhz_r});
            clock_present <= clk_valid_r || clk_ovr_r;
            link_ready    <= bcl_q2_r || link_ovr_r;
        end
    end

    // Reset pulses: PLL on frequency change, PHY on frequency or mode change
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pll_reset <= 1'b0;
            phy_reset <= 1'b0;
        end else begin
            pll_reset <= chg && pll_roc_r;
            phy_reset <= (chg || mode_change) && !(phy_policy_r && p5_q2_r);
        end
    end

    // Read port; unmapped offsets and reserved bits return zero
    always_ff @(posedge clk) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == `TCM_ADDR_LINK_CTL) begin
                reg_rdata <= {1'b0, lane_swap, pll_roc_r, meter_src_r, 4'h0};
            end else if (reg_addr == `TCM_ADDR_DUAL_LINK_CONTROL_TWO) begin
                reg_rdata <= {swap_inhibit_r, link_ovr_r, clk_ovr_r, stability_time_select_r, measure_deadband_r};
            end else if (reg_addr == `TCM_ADDR_LOW_LIMIT) begin
                reg_rdata <= {1'b0, phy_policy_r, tmds_min_mhz_r};
            end else if (reg_addr == `TCM_ADDR_HIGH_LIMIT) begin
                reg_rdata <= {1'b0, tmds_max_mhz_r};
            end else if (reg_addr == `TCM_ADDR_MEASURED) begin
                reg_rdata <= clock_present ? cur_mhz_r : 8'h00;
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_link_ovr;
        link_ovr_r |=> link_ready;
    endproperty
    a_link_ovr: assert property (p_link_ovr) else $error("link ready not forced");

    property p_clk_ovr;
        clk_ovr_r |=> clock_present;
    endproperty
    a_clk_ovr: assert property (p_clk_ovr) else $error("clock present not forced");

    property p_deadband_hold;
        meas_done && (abs_diff(meas_mhz, cur_mhz_r) <= {5'h00, measure_deadband_r}) |=> $stable(cur_mhz_r);
    endproperty
    a_deadband_hold: assert property (p_deadband_hold) else $error("held value moved inside deadband");

    property p_measured_zero;
        reg_rd && reg_addr == `TCM_ADDR_MEASURED && !clock_present |=> reg_rdata == 8'h00;
    endproperty
    a_measured_zero: assert property (p_measured_zero) else $error("measured not zero without clock");

    property p_pll_reset;
        chg && pll_roc_r |=> pll_reset;
    endproperty
    a_pll_reset: assert property (p_pll_reset) else $error("pll reset missing");

    property p_phy_reset;
        chg && !phy_policy_r |=> phy_reset;
    endproperty
    a_phy_reset: assert property (p_phy_reset) else $error("phy reset missing");

    property p_phy_skip;
        phy_policy_r && p5_q2_r |=> !phy_reset;
    endproperty
    a_phy_skip: assert property (p_phy_skip) else $error("phy reset despite +5V");

    property p_valid_limits;
        clk_valid_r |-> (cur_mhz_r >= {2'h0, $past(tmds_min_mhz_r)}) && $past(stable_r);
    endproperty
    a_valid_limits: assert property (p_valid_limits) else $error("valid below low limit");

    property p_restart;
        chg |=> !stable_r ##1 !clk_valid_r;
    endproperty
    a_restart: assert property (p_restart) else $error("stability not restarted");

    property p_swap_auto;
        !swap_inhibit_r |=> lane_swap == $past(swp_q2_r);
    endproperty
    a_swap_auto: assert property (p_swap_auto) else $error("swap not following detect");

    property p_reserved;
        reg_rd && reg_addr == `TCM_ADDR_HIGH_LIMIT |=> !reg_rdata[7];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit not zero");
endmodule

// ==== tcm_params.svh ====
// Constants for the TMDS clock frequency monitor: register offsets,
// field positions, reset values and timing counts.
// Assumes a 10 MHz block clock.
`ifndef TCM_PARAMS_SVH
`define TCM_PARAMS_SVH

// Register offsets
`define TCM_ADDR_LINK_CTL      8'h5B
`define TCM_ADDR_DUAL_LINK_CONTROL_TWO     8'h5C
`define TCM_ADDR_LOW_LIMIT     8'h5D
`define TCM_ADDR_HIGH_LIMIT    8'h5E
`define TCM_ADDR_MEASURED      8'h5F

// Field positions
`define TCM_BIT_SWAP_STATE     6
`define TCM_BIT_PLL_ROC        5
`define TCM_BIT_METER_SRC      4
`define TCM_BIT_SWAP_INHIBIT   7
`define TCM_BIT_LINK_OVR       6
`define TCM_BIT_CLK_OVR        5
`define TCM_STAB_MSB           4
`define TCM_STAB_LSB           3
`define TCM_DB_MSB             2
`define TCM_BIT_PHY_POLICY     6
`define TCM_MIN_MSB            5
`define TCM_MAX_MSB            6

// Reset values
`define TCM_RST_DEADBAND       3'h2
`define TCM_RST_MIN_MHZ        6'h06
`define TCM_RST_MAX_MHZ        7'h44
`define TCM_RST_PLL_ROC        1'h1

// Timing
`define TCM_CLK_MHZ            10
`define TCM_GATE_NS            1000
`define TCM_GATE_CYC           ((`TCM_GATE_NS * `TCM_CLK_MHZ) / 1000)
`define TCM_STAB0_NS           40000
`define TCM_STAB1_NS           80000
`define TCM_STAB2_NS           320000
`define TCM_STAB3_NS           1280000
`define TCM_NS2CYC(ns)         (((ns) * `TCM_CLK_MHZ + 999) / 1000)

`endif

// ==== tcm_pkg.sv ====
// Types shared by the TMDS clock frequency monitor files.
// Assumes tcm_params.svh supplies the numeric constants.
package tcm_pkg;
    typedef logic [7:0] tcm_byte_t;
    typedef logic [15:0] tcm_cnt_t;
    typedef enum logic {TCM_SRC_TMDS, TCM_SRC_PLL} tcm_src_t;
endpackage

// ==== tcm_edge_meter.sv ====
// Edge meter: counts rising edges of the selected clock per 1 us gate.
// Assumes both measured clocks are asynchronous pins; each passes two flops.
`timescale 1ns/1ps
`include "tcm_params.svh"
module tcm_edge_meter
    import tcm_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      resetn,
    input  wire logic      tmds_clk,
    input  wire logic      pll_clk,
    input  wire tcm_src_t  src_sel,
    output logic           meas_done,
    output tcm_byte_t      meas_mhz
);
    logic      tmds_q1_r, tmds_q2_r, pll_q1_r, pll_q2_r, prev_r;
    logic      sel_lvl, rise;
    tcm_byte_t gate_r, edges_r;

    // Two-flop synchronisers; only the second stage is read
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tmds_q1_r <= 1'b0;
            tmds_q2_r <= 1'b0;
            pll_q1_r  <= 1'b0;
            pll_q2_r  <= 1'b0;
        end else begin
            tmds_q1_r <= tmds_clk;
            tmds_q2_r <= tmds_q1_r;
            pll_q1_r  <= pll_clk;
            pll_q2_r  <= pll_q1_r;
        end
    end

    // Source choice after the synchronisers, so a switch never glitches a flop
    assign sel_lvl = (src_sel == TCM_SRC_PLL) ? pll_q2_r : tmds_q2_r;
    assign rise    = sel_lvl & ~prev_r;

    // Gate counter; sampling at 10 MHz resolves clocks below 5 MHz only
    always_ff @(posedge clk) begin
        if (!resetn) begin
            prev_r    <= 1'b0;
            gate_r    <= 8'h00;
            edges_r   <= 8'h00;
            meas_done <= 1'b0;
            meas_mhz  <= 8'h00;
        end else begin
            prev_r    <= sel_lvl;
            meas_done <= 1'b0;
            if (gate_r == 8'(`TCM_GATE_CYC - 1)) begin
                gate_r    <= 8'h00;
                edges_r   <= 8'h00;
                meas_done <= 1'b1;
                meas_mhz  <= edges_r + {7'h00, rise};
            end else begin
                gate_r  <= gate_r + 8'h01;
                edges_r <= edges_r + {7'h00, rise};
            end
        end
    end
endmodule

// ==== tcm_video_source.sv ====
// Video source model: drives the TMDS clock pin and the receiver PLL clock pin.
// Assumes the bench enables each clock; a disabled clock stands still at 0.
`timescale 1ns/1ps
module tcm_video_source #(
    parameter int TMDS_HALF_NS = 400,
    parameter int PLL_HALF_NS  = 400
)
(
    input  wire logic tmds_en,
    input  wire logic pll_en,
    output logic      tmds_clk,
    output logic      pll_clk
);
    // Free running TMDS clock, offset so its phase is unrelated to clk
    initial begin
        tmds_clk = 1'b0;
        #37;
        forever begin
            #(TMDS_HALF_NS);
            tmds_clk = tmds_en ? ~tmds_clk : 1'b0;
        end
    end

    // PLL clock with its own phase and, by default, the same rate as the TMDS clock
    initial begin
        pll_clk = 1'b0;
        #113;
        forever begin
            #(PLL_HALF_NS);
            pll_clk = pll_en ? ~pll_clk : 1'b0;
        end
    end
endmodule

// ==== tb_top.sv ====
// Testbench for the TMDS clock frequency monitor, through its register strobes.
// Assumes a 10 MHz clk; a 1.25 MHz source gives 1 or 2 edges per 1 us gate.
`timescale 1ns/1ps
`include "tcm_params.svh"
module tb_top;
    import tcm_pkg::*;

    logic      clk, resetn, plus_5v_detect, back_channel_link_detect;
    logic      swap_detect, mode_change, reg_wr, reg_rd, tmds_en, pll_en;
    tcm_byte_t reg_addr, reg_wdata, reg_rdata;
    logic      tmds_clk, pll_clk, clock_present, link_ready, lane_swap, pll_reset, phy_reset;
    int        num_errors, n_compared, n_pll, n_phy;
    tcm_byte_t rst_tab [5] = '{8'h20, 8'h02, 8'h06, 8'h44, 8'h00};

    tcm_freq_monitor #(.STAB3_CYC(200)) i_tcm_freq_monitor (
        .clk(clk), .resetn(resetn), .tmds_clk(tmds_clk), .pll_clk(pll_clk),
        .plus_5v_detect(plus_5v_detect), .back_channel_link_detect(back_channel_link_detect),
        .swap_detect(swap_detect), .mode_change(mode_change), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .clock_present(clock_present), .link_ready(link_ready), .lane_swap(lane_swap),
        .pll_reset(pll_reset), .phy_reset(phy_reset));

    tcm_video_source i_tcm_video_source (
        .tmds_en(tmds_en), .pll_en(pll_en), .tmds_clk(tmds_clk), .pll_clk(pll_clk));

    // 100 ns block clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Count reset pulses; each stands one cycle, sampled mid-cycle where it is settled
    always @(negedge clk) begin
        if (pll_reset === 1'b1) n_pll++;
        if (phy_reset === 1'b1) n_phy++;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk_byte(input tcm_byte_t got, input tcm_byte_t exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: byte got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: flag got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic wr(input tcm_byte_t a, input tcm_byte_t d);
        step(1);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        step(1);
        reg_wr    = 1'b0;
    endtask

    // Read data lands on the edge that samples the strobe and stands until the next read
    task automatic rd(input tcm_byte_t a, input tcm_byte_t exp);
        step(1);
        reg_addr = a;
        reg_rd   = 1'b1;
        step(1);
        reg_rd   = 1'b0;
        step(1);
        chk_byte(reg_rdata, exp);
    endtask

    task automatic pulse_mode;
        step(1);
        mode_change = 1'b1;
        step(1);
        mode_change = 1'b0;
    endtask

    task automatic wrap_up;
        $display("errors %0d, comparisons %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Watchdog: the sequence needs about 2000 cycles
    initial begin
        #3000000;
        num_errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        wrap_up();
    end

    initial begin
        {resetn, plus_5v_detect, back_channel_link_detect, swap_detect} = 4'h0;
        {mode_change, reg_wr, reg_rd, tmds_en, pll_en} = 5'h00;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        num_errors = 0;
        n_compared = 0;
        n_pll = 0;
        n_phy = 0;
        step(4);
        resetn = 1'b1;
        // Reset values of the whole slice, then an unmapped offset
        for (int i = 0; i < 5; i++) rd(8'h5B + 8'(i), rst_tab[i]);
        rd(8'h60, 8'h00);
        wr(`TCM_ADDR_HIGH_LIMIT, 8'hFF);
        rd(`TCM_ADDR_HIGH_LIMIT, 8'h7F);
        wr(`TCM_ADDR_HIGH_LIMIT, 8'h44);
        wr(`TCM_ADDR_MEASURED, 8'hAA);
        rd(`TCM_ADDR_MEASURED, 8'h00);
        // Swap state follows detection and refuses writes until inhibited
        swap_detect = 1'b1;
        step(6);
        chk_bit(lane_swap, 1'b1);
        wr(`TCM_ADDR_LINK_CTL, 8'h20);
        chk_bit(lane_swap, 1'b1);
        step(2);
        chk_bit(lane_swap, 1'b1);
        wr(`TCM_ADDR_DUAL_LINK_CONTROL_TWO, 8'h82);
        wr(`TCM_ADDR_LINK_CTL, 8'h20);
        step(2);
        chk_bit(lane_swap, 1'b0);
        rd(`TCM_ADDR_LINK_CTL, 8'h20);
        swap_detect = 1'b0;
        // Link ready from override, then from the synced detect
        chk_bit(link_ready, 1'b0);
        wr(`TCM_ADDR_DUAL_LINK_CONTROL_TWO, 8'hC2);
        step(2);
        chk_bit(link_ready, 1'b1);
        wr(`TCM_ADDR_DUAL_LINK_CONTROL_TWO, 8'h02);
        back_channel_link_detect = 1'b1;
        step(6);
        chk_bit(link_ready, 1'b1);
        // Deadband 1 MHz, 40 us stability, min 1 MHz, then start the source
        wr(`TCM_ADDR_DUAL_LINK_CONTROL_TWO, 8'h01);
        wr(`TCM_ADDR_LOW_LIMIT, 8'h01);
        n_pll = 0;
        n_phy = 0;
        tmds_en = 1'b1;
        step(300);
        chk_bit(clock_present, 1'b0);
        step(400);
        chk_bit(clock_present, 1'b1);
        rd(`TCM_ADDR_MEASURED, 8'h02);
        chk_bit(n_pll != 0, 1'b1);
        chk_bit(n_phy != 0, 1'b1);
        // Phy reset policy 1 skips the reset only while +5 V is seen
        wr(`TCM_ADDR_LOW_LIMIT, 8'h41);
        plus_5v_detect = 1'b1;
        step(5);
        n_phy = 0;
        pulse_mode();
        step(10);
        chk_bit(n_phy == 0, 1'b1);
        plus_5v_detect = 1'b0;
        step(5);
        pulse_mode();
        step(10);
        chk_bit(n_phy == 1, 1'b1);
        // Held 2 MHz below a 3 MHz floor: not present, reads zero
        wr(`TCM_ADDR_LOW_LIMIT, 8'h03);
        step(20);
        chk_bit(clock_present, 1'b0);
        rd(`TCM_ADDR_MEASURED, 8'h00);
        wr(`TCM_ADDR_DUAL_LINK_CONTROL_TWO, 8'h21);
        step(5);
        chk_bit(clock_present, 1'b1);
        wr(`TCM_ADDR_DUAL_LINK_CONTROL_TWO, 8'h01);
        wr(`TCM_ADDR_LOW_LIMIT, 8'h01);
        wr(`TCM_ADDR_HIGH_LIMIT, 8'h01);
        step(20);
        chk_bit(clock_present, 1'b0);
        wr(`TCM_ADDR_HIGH_LIMIT, 8'h44);
        step(20);
        chk_bit(clock_present, 1'b1);
        // PLL reset off, then the source stops: no PLL pulse, clock lost
        wr(`TCM_ADDR_LINK_CTL, 8'h00);
        n_pll = 0;
        tmds_en = 1'b0;
        step(50);
        chk_bit(n_pll == 0, 1'b1);
        chk_bit(clock_present, 1'b0);
        // Meter switched to the PLL clock recovers the measurement
        wr(`TCM_ADDR_LINK_CTL, 8'h30);
        pll_en = 1'b1;
        step(700);
        chk_bit(clock_present, 1'b1);
        chk_bit(n_pll != 0, 1'b1);
        rd(`TCM_ADDR_MEASURED, 8'h02);
        // Longest stability code: lose the clock, restore it, valid after the shortened count
        wr(`TCM_ADDR_DUAL_LINK_CONTROL_TWO, 8'h19);
        pll_en = 1'b0;
        step(50);
        chk_bit(clock_present, 1'b0);
        pll_en = 1'b1;
        step(120);
        chk_bit(clock_present, 1'b0);
        step(180);
        chk_bit(clock_present, 1'b1);
        rd(`TCM_ADDR_DUAL_LINK_CONTROL_TWO, 8'h19);
        wrap_up();
    end
endmodule
